// ### pkg/gsl_map.vh
// Timing and pattern constants for the gateway status LED driver.
// Assumes a 125 MHz system clock; included by the driver module only.
`ifndef GSL_MAP_VH
`define GSL_MAP_VH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define GSL_CLK_MHZ        125
`define GSL_TICK_NS        10000000
`define GSL_TICK_CYC       ((`GSL_TICK_NS / 1000) * `GSL_CLK_MHZ)

// ----------------------------------------------------------------
// Flash periods, in 10 ms ticks
// ----------------------------------------------------------------
`define GSL_FAST_MS        160
`define GSL_FAST_TICKS     (`GSL_FAST_MS / 10)
`define GSL_SLOW_MS        1000
`define GSL_SLOW_TICKS     (`GSL_SLOW_MS / 10)
`define GSL_BLINK_TICKS    8'h19
`define GSL_GROUP_GAP      8'h64

// ----------------------------------------------------------------
// Flash counts of the active LED groups
// ----------------------------------------------------------------
`define GSL_CNT_IDLE       4'h2
`define GSL_CNT_ALONE      4'h3
`define GSL_CNT_DUP        4'h4

// ----------------------------------------------------------------
// Device-status states
// ----------------------------------------------------------------
`define GSL_DEV_INIT       3'h0
`define GSL_DEV_RUN        3'h1
`define GSL_DEV_CFGBAD     3'h2
`define GSL_DEV_FAULT      3'h3
`define GSL_DEV_BOOT       3'h4

`endif

// ### rtl/gsl_led_driver.v
// Front-panel status LED driver: active, subnet-status, device-status.
// Assumes all status inputs are synchronous to MCLK and held as levels,
// except the one-cycle transaction event pulses.
`timescale 1ns/1ps
`include "gsl_map.vh"

module gsl_led_driver #(
   parameter TICK_CYC = `GSL_TICK_CYC,  // Cycles per 10 ms tick
   parameter NTRANS   = 8               // Configured transactions
) (
   // Clock and reset
   input  wire              MCLK,
   input  wire              RST,
   // Fieldbus status
   input  wire              FB_RUN,
   input  wire              OFFLINE_LISTEN_STATE,
   input  wire              TOKEN_WAIT_IDLE_STATE,
   input  wire              FB_ALONE,
   input  wire              FB_DUP_NODE,
   // Subnetwork status
   input  wire              SUB_RUN,
   input  wire [NTRANS-1:0] TRANS_CFG,
   input  wire [NTRANS-1:0] TRANS_OK,
   input  wire              TRANS_FAIL,
   // Device supervisor
   input  wire              CFG_VALID,
   input  wire              BOOT_MODE,
   input  wire              DEV_INIT_DONE,
   input  wire [3:0]        FAULT_CODE,
   // LED drive
   output reg               ACT_LED,
   output reg               SUB_GRN,
   output reg               SUB_RED,
   output reg               DEV_GRN,
   output reg               DEV_RED
);

   // ----------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------
   reg  [23:0] div_q;      // Cycle divider
   reg         tick_q;     // One-cycle 10 ms enable
   reg  [7:0]  fast_q;     // 160 ms phase
   reg  [7:0]  slow_q;     // 1 s phase

   // Divider produces the single tick enable all patterns use
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         div_q  <= 24'h000000;
         tick_q <= 1'b0;
      end else if (div_q == TICK_CYC[23:0] - 24'h000001) begin
         div_q  <= 24'h000000;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 24'h000001;
         tick_q <= 1'b0;
      end
   end

   // Free-running phase counters for steady flash rates
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         fast_q <= 8'h00;
         slow_q <= 8'h00;
      end else if (tick_q) begin
         fast_q <= (fast_q == `GSL_FAST_TICKS - 1) ? 8'h00 : fast_q + 8'h01;
         slow_q <= (slow_q == `GSL_SLOW_TICKS - 1) ? 8'h00 : slow_q + 8'h01;
      end
   end

   wire fast_on = (fast_q < (`GSL_FAST_TICKS / 2));   // Half duty
   wire slow_on = (slow_q < (`GSL_SLOW_TICKS / 2));

   // ----------------------------------------------------------------
   // Flash-group engine, shared by active and device LEDs
   // ----------------------------------------------------------------
   // Group sequencer: N blinks then a long gap, repeat
   function [4:0] grp_next;
      input [4:0] pos;     // Blink slot index; slot 2k = on
      input [3:0] n;
      begin
         if (pos >= {n, 1'b0})
            grp_next = 5'h00;
         else
            grp_next = pos + 5'h01;
      end
   endfunction

   reg  [4:0] agrp_q;      // Active LED slot
   reg  [7:0] atim_q;      // Active LED slot timer
   reg  [4:0] dgrp_q;      // Device LED slot
   reg  [7:0] dtim_q;      // Device LED slot timer
   reg  [3:0] a_cnt;       // Active group size, 0 = none

   // Priority: duplicate node beats alone beats idle
   always @* begin
      if (FB_DUP_NODE)
         a_cnt = `GSL_CNT_DUP;
      else if (FB_ALONE)
         a_cnt = `GSL_CNT_ALONE;
      else if (TOKEN_WAIT_IDLE_STATE)
         a_cnt = `GSL_CNT_IDLE;
      else
         a_cnt = 4'h0;
   end

   // Fault group: red count then one green marker slot
   wire [3:0] d_cnt = (FAULT_CODE == 4'h0) ? 4'h1 : FAULT_CODE;

   // Slot timers; the last slot of a group is the long gap
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         agrp_q <= 5'h00;
         atim_q <= 8'h00;
         dgrp_q <= 5'h00;
         dtim_q <= 8'h00;
      end else if (tick_q) begin
         if (atim_q == ((agrp_q == {a_cnt, 1'b0}) ? `GSL_GROUP_GAP : `GSL_BLINK_TICKS)) begin
            atim_q <= 8'h00;
            agrp_q <= grp_next(agrp_q, a_cnt);
         end else begin
            atim_q <= atim_q + 8'h01;
         end
         // Slot 2N is the green marker, slot 2N+1 the gap; fits five bits
         // even for code 15, and >= stops a code change from wrapping the timer
         if (dtim_q >= ((dgrp_q > {d_cnt, 1'b0}) ? `GSL_GROUP_GAP : `GSL_BLINK_TICKS)) begin
            dtim_q <= 8'h00;
            dgrp_q <= (dgrp_q > {d_cnt, 1'b0}) ? 5'h00 : dgrp_q + 5'h01;
         end else begin
            dtim_q <= dtim_q + 8'h01;
         end
      end
   end

   wire a_blink = ~agrp_q[0] && (agrp_q < {a_cnt, 1'b0});
   wire d_red   = ~dgrp_q[0] && (dgrp_q < {d_cnt, 1'b0});
   wire d_grn   = ~dgrp_q[0] && (dgrp_q == {d_cnt, 1'b0});

   // ----------------------------------------------------------------
   // Active LED
   // ----------------------------------------------------------------
   always @(posedge MCLK or posedge RST) begin
      if (RST)
         ACT_LED <= 1'b0;
      else if (a_cnt != 4'h0)
         ACT_LED <= a_blink;
      else if (OFFLINE_LISTEN_STATE)
         ACT_LED <= slow_on;
      else if (FB_RUN)
         ACT_LED <= fast_on;
      else
         ACT_LED <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Subnet-status LED
   // ----------------------------------------------------------------
   reg [NTRANS-1:0] seen_q;   // Transactions active at least once
   reg              err_q;    // Error recorded since start
   reg              fail_q;   // Current failure, until a configured transaction reruns

   // Sticky tracking; new events beat the clear on subnet stop
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         seen_q <= {NTRANS{1'b0}};
         err_q  <= 1'b0;
         fail_q <= 1'b0;
      end else if (!SUB_RUN) begin
         seen_q <= TRANS_OK;
         err_q  <= TRANS_FAIL;
         fail_q <= TRANS_FAIL;
      end else begin
         seen_q <= seen_q | TRANS_OK;
         err_q  <= err_q | TRANS_FAIL;
         if (TRANS_FAIL)
            fail_q <= 1'b1;
         else if ((TRANS_OK & TRANS_CFG) != {NTRANS{1'b0}})
            fail_q <= 1'b0;
      end
   end

   wire all_seen = ((seen_q & TRANS_CFG) == TRANS_CFG);

   // Red wins; after an error green flashes, otherwise steady green only after full coverage
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         SUB_GRN <= 1'b0;
         SUB_RED <= 1'b0;
      end else if (!SUB_RUN || fail_q || TRANS_FAIL) begin
         SUB_GRN <= 1'b0;
         SUB_RED <= 1'b1;
      end else if (err_q) begin
         SUB_GRN <= fast_on;
         SUB_RED <= 1'b0;
      end else begin
         SUB_GRN <= all_seen;
         SUB_RED <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Device-status LED
   // ----------------------------------------------------------------
   reg [2:0] dev_st;   // Device display state

   // Bootloader over fault over configuration over run
   always @* begin
      if (BOOT_MODE)
         dev_st = `GSL_DEV_BOOT;
      else if (FAULT_CODE != 4'h0)
         dev_st = `GSL_DEV_FAULT;
      else if (!CFG_VALID)
         dev_st = `GSL_DEV_CFGBAD;
      else if (DEV_INIT_DONE)
         dev_st = `GSL_DEV_RUN;
      else
         dev_st = `GSL_DEV_INIT;
   end

   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         DEV_GRN <= 1'b0;
         DEV_RED <= 1'b0;
      end else begin
         case (dev_st)
            `GSL_DEV_BOOT: begin
               DEV_GRN <= 1'b0;
               DEV_RED <= 1'b1;
            end
            `GSL_DEV_FAULT: begin
               DEV_GRN <= d_grn;
               DEV_RED <= d_red;
            end
            `GSL_DEV_CFGBAD: begin
               DEV_GRN <= ~slow_on;
               DEV_RED <= slow_on;
            end
            `GSL_DEV_RUN: begin
               DEV_GRN <= slow_on;
               DEV_RED <= 1'b0;
            end
            default: begin
               DEV_GRN <= 1'b1;
               DEV_RED <= 1'b0;
            end
         endcase
      end
   end

endmodule // gsl_led_driver

// ### verification/gsl_led_driver_chk.sv
// Port checker for the gateway status LED driver.
// Bound to gsl_led_driver; sees only its ports, one clock domain.
`timescale 1ns/1ps
module gsl_led_chk #(
   parameter TICK_CYC = 4,  // Cycles per pattern tick
   parameter NTRANS   = 8   // Configured transactions
) (
   // Clock, reset and fieldbus status
   input wire              MCLK, RST, FB_RUN, OFFLINE_LISTEN_STATE,
   input wire              TOKEN_WAIT_IDLE_STATE, FB_ALONE, FB_DUP_NODE,
   // Subnetwork status
   input wire              SUB_RUN, TRANS_FAIL,
   input wire [NTRANS-1:0] TRANS_CFG, TRANS_OK,
   // Supervisor and LED drive
   input wire              CFG_VALID, BOOT_MODE, DEV_INIT_DONE,
   input wire [3:0]        FAULT_CODE,
   input wire              ACT_LED, SUB_GRN, SUB_RED, DEV_GRN, DEV_RED
);
   // Normal operation with no higher active pattern
   wire run_only = FB_RUN && !FB_DUP_NODE && !FB_ALONE && !TOKEN_WAIT_IDLE_STATE
                   && !OFFLINE_LISTEN_STATE;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   property p_boot; BOOT_MODE |=> DEV_RED && !DEV_GRN; endproperty
   a_boot: assert property (p_boot) else $error("boot red wrong");
   property p_stop; !SUB_RUN |=> SUB_RED && !SUB_GRN; endproperty
   a_stop: assert property (p_stop) else $error("stop red wrong");
   property p_fail; TRANS_FAIL |=> SUB_RED; endproperty
   a_fail: assert property (p_fail) else $error("fail red wrong");
   property p_excl; !(SUB_RED && SUB_GRN); endproperty
   a_excl: assert property (p_excl) else $error("subnet colours mixed");
   property p_grn; SUB_GRN |-> $past(SUB_RUN); endproperty
   a_grn: assert property (p_grn) else $error("green while stopped");
   property p_cfg; !CFG_VALID && !BOOT_MODE && FAULT_CODE == 4'h0 |=> (DEV_RED ^ DEV_GRN);
   endproperty
   a_cfg: assert property (p_cfg) else $error("alternate colours mixed");
   property p_flt; FAULT_CODE != 4'h0 && !BOOT_MODE |=> !(DEV_RED && DEV_GRN); endproperty
   a_flt: assert property (p_flt) else $error("fault colours mixed");
   property p_dup; FB_DUP_NODE && $rose(ACT_LED) ##1 FB_DUP_NODE [*7] |-> ACT_LED; endproperty
   a_dup: assert property (p_dup) else $error("dup blink too short");
   property p_run; run_only && $rose(ACT_LED) ##1 run_only [*7] |-> ACT_LED; endproperty
   a_run: assert property (p_run) else $error("fast blink too short");
endmodule // gsl_led_chk
bind gsl_led_driver gsl_led_chk #(.TICK_CYC(TICK_CYC), .NTRANS(NTRANS)) u_chk (
   .MCLK(MCLK), .RST(RST), .FB_RUN(FB_RUN), .OFFLINE_LISTEN_STATE(OFFLINE_LISTEN_STATE),
   .TOKEN_WAIT_IDLE_STATE(TOKEN_WAIT_IDLE_STATE), .FB_ALONE(FB_ALONE),
   .FB_DUP_NODE(FB_DUP_NODE), .SUB_RUN(SUB_RUN), .TRANS_FAIL(TRANS_FAIL),
   .TRANS_CFG(TRANS_CFG), .TRANS_OK(TRANS_OK), .CFG_VALID(CFG_VALID),
   .BOOT_MODE(BOOT_MODE), .DEV_INIT_DONE(DEV_INIT_DONE), .FAULT_CODE(FAULT_CODE),
   .ACT_LED(ACT_LED), .SUB_GRN(SUB_GRN), .SUB_RED(SUB_RED), .DEV_GRN(DEV_GRN),
   .DEV_RED(DEV_RED));

// ### verification/tb.sv
// Self-checking bench for the status LED driver.
// Drives all inputs at the falling edge; tick shortened to 4 cycles.
`timescale 1ns/1ps
module tb;
   localparam TCK = 4;                      // Cycles per tick in simulation
   logic MCLK, RST, FB_RUN, OFL, IDL, FB_ALONE, FB_DUP_NODE, SUB_RUN, TRANS_FAIL;
   logic CFG_VALID, BOOT_MODE, DEV_INIT_DONE;
   logic [7:0] TRANS_CFG, TRANS_OK;         // Transaction mask and pulses
   logic [3:0] FAULT_CODE;                  // Fault under test
   wire  ACT_LED, SUB_GRN, SUB_RED, DEV_GRN, DEV_RED;
   int   n_errors = 0, cmp_count = 0, cyc_n = 0, k;
   gsl_led_driver #(.TICK_CYC(TCK), .NTRANS(8)) uut (.MCLK(MCLK), .RST(RST),
      .FB_RUN(FB_RUN), .OFFLINE_LISTEN_STATE(OFL), .TOKEN_WAIT_IDLE_STATE(IDL),
      .FB_ALONE(FB_ALONE), .FB_DUP_NODE(FB_DUP_NODE), .SUB_RUN(SUB_RUN),
      .TRANS_CFG(TRANS_CFG), .TRANS_OK(TRANS_OK), .TRANS_FAIL(TRANS_FAIL),
      .CFG_VALID(CFG_VALID), .BOOT_MODE(BOOT_MODE), .DEV_INIT_DONE(DEV_INIT_DONE),
      .FAULT_CODE(FAULT_CODE), .ACT_LED(ACT_LED), .SUB_GRN(SUB_GRN), .SUB_RED(SUB_RED),
      .DEV_GRN(DEV_GRN), .DEV_RED(DEV_RED));
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   // Hang guard; patterns should settle well inside this
   always @(posedge MCLK) begin
      cyc_n++;
      if (cyc_n == 60000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   function automatic logic led(input int s);
      case (s)
         0: led = ACT_LED;
         1: led = DEV_RED;
         2: led = DEV_GRN;
         default: led = SUB_GRN;
      endcase
   endfunction
   // Wait for a rising LED; returns the cycles spent waiting
   task automatic up(input int s, output int n);
      logic p;
      p = 1'b1;
      n = 0;
      forever begin
         @(negedge MCLK);
         n++;
         if (led(s) === 1'b1 && !p) break;
         p = led(s);
      end
   endtask
   // Rises of LED c between two rises of LED m
   task automatic betw(input int m, c, output int k);
      logic pm, pc;
      int n;
      up(m, n);
      k = 0;
      pm = 1'b1;
      pc = led(c);
      forever begin
         @(negedge MCLK);
         if (led(c) === 1'b1 && !pc) k++;
         if (led(m) === 1'b1 && !pm) break;
         pc = led(c);
         pm = led(m);
      end
   endtask
   // Flashes of the active LED in one group, framed by long gaps
   task automatic grp(input logic [15:0] exp);
      int off;
      logic [15:0] n;
      logic p;
      off = 0;
      n = 0;
      p = 1'b1;
      while (off < 60 * TCK) begin
         @(negedge MCLK);
         off = (ACT_LED === 1'b0) ? off + 1 : 0;
      end
      while (!(n != 0 && off >= 60 * TCK)) begin
         @(negedge MCLK);
         if (ACT_LED === 1'b1 && !p) n++;
         off = (ACT_LED === 1'b0) ? off + 1 : 0;
         p = ACT_LED;
      end
      chk("act_group", n, exp);
   endtask
   task automatic ok_pulse(input logic [7:0] v);
      TRANS_OK = v;
      @(negedge MCLK);
      TRANS_OK = 8'h00;
      repeat (2) @(negedge MCLK);
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   // Stack active conditions so each level beats the one below
   task automatic t_active();
      int n;
      FB_RUN = 1'b1;
      up(0, n);
      up(0, n);
      chk("fast_period", n, 16 * TCK);
      OFL = 1'b1;
      up(0, n);
      up(0, n);
      chk("slow_period", n, 100 * TCK);
      IDL = 1'b1;
      grp(16'h0002);
      FB_ALONE = 1'b1;
      grp(16'h0003);
      FB_DUP_NODE = 1'b1;
      grp(16'h0004);
   endtask
   task automatic t_subnet();
      int n;
      TRANS_CFG = 8'h03;
      SUB_RUN = 1'b1;
      ok_pulse(8'h01);
      chk("grn_partial", SUB_GRN, 1'b0);
      ok_pulse(8'h02);
      chk("grn_all", {SUB_GRN, SUB_RED}, 2'b10);
      TRANS_FAIL = 1'b1;
      @(negedge MCLK);
      TRANS_FAIL = 1'b0;
      @(negedge MCLK);
      chk("red_fail", SUB_RED, 1'b1);
      ok_pulse(8'h01);
      up(3, n);
      up(3, n);
      chk("grn_flash", SUB_RED, 1'b0);
      SUB_RUN = 1'b0;
      repeat (2) @(negedge MCLK);
      chk("red_stop", SUB_RED, 1'b1);
   endtask
   task automatic t_device();
      CFG_VALID = 1'b0;
      betw(2, 1, k);
      chk("cfg_alt", k, 1);
      CFG_VALID = 1'b1;
      for (int c = 1; c < 4; c++) begin
         FAULT_CODE = 4'(c);
         betw(2, 1, k);
         betw(2, 1, k);
         chk("fault_reds", 16'(k), 16'(c));
      end
      BOOT_MODE = 1'b1;
      repeat (2) @(negedge MCLK);
      chk("boot_red", {DEV_RED, DEV_GRN}, 2'b10);
   endtask
   initial begin
      {RST, FB_RUN, OFL, IDL, FB_ALONE, FB_DUP_NODE, SUB_RUN, TRANS_FAIL} = 8'h80;
      {CFG_VALID, BOOT_MODE, DEV_INIT_DONE} = 3'h5;
      {TRANS_CFG, TRANS_OK, FAULT_CODE} = 20'h00000;
      repeat (20) @(negedge MCLK);
      RST = 1'b0;
      t_active();
      t_subnet();
      t_device();
      tally_and_finish();
   end
endmodule // tb
